// file: inc/misoperation_guard_defines.vh
/*
  Constants for the misoperation guard: setting codes, register offsets,
  reset values and timing counts.
  Assumes it is included by bare name from design and bench files.
*/
`ifndef MISOPERATION_GUARD_DEFINES_VH
`define MISOPERATION_GUARD_DEFINES_VH

// Register offsets on the plain register port
`define MG_ADDR_GUARD 4'h0
`define MG_ADDR_WPROT 4'h1
`define MG_ADDR_STOPSEL 4'h2
`define MG_ADDR_SRCSEL 4'h3
`define MG_ADDR_OPMODE 4'h4
`define MG_ADDR_PARAM_REQ 4'h5
`define MG_ADDR_STATUS 4'h6
`define MG_ADDR_ACCUM 4'h7

// Reset values
`define MG_GUARD_RESET 5'h0E
`define MG_WPROT_RESET 2'h0
`define MG_STOPSEL_RESET 14'h270F
`define MG_SRCSEL_RESET 14'h270F
`define MG_OPMODE_RESET 2'h0

// Encodings
`define MG_CODE_COAST_OFF 14'h270F
`define MG_CODE_PU_PRIORITY 14'h270F
`define MG_WP_STOP_ONLY 2'h0
`define MG_WP_INHIBIT 2'h1
`define MG_WP_ALWAYS 2'h2
`define MG_MODE_PANEL 2'h0
`define MG_MODE_EXTERNAL 2'h1
`define MG_MODE_NETWORK 2'h2
`define MG_FAULT_PANEL_LOSS 8'h41

// Parameter numbers that the write gate knows by number
`define MG_PNUM_STALL_LEVEL 10'h016
`define MG_PNUM_GUARD 10'h04B
`define MG_PNUM_WPROT 10'h04D
`define MG_PNUM_OPMODE 10'h04F
`define MG_PNUM_DISPLAY 10'h0A0
`define MG_PNUM_PW_LEVEL 10'h128
`define MG_PNUM_PW_LOCK 10'h129

// Timing
`define MG_CLK_HZ 10000000
`define MG_LOSS_TIME_MS 1000
`define MG_LOSS_CYCLES ((`MG_CLK_HZ / 1000) * `MG_LOSS_TIME_MS)

`endif

// file: src/misoperation_guard.v
/*
  Misoperation guard of a motor drive: reset acceptance, panel-loss trip,
  panel-stop latch and parameter write gating, with a small register port.
  Assumes panel, terminal and link inputs are asynchronous and the output
  stage and parameter store sit on the same 10 MHz clock.
*/
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ns
`include "misoperation_guard_defines.vh"

// What this block does
// - Guard 1,3,15,17: pin or link reset accepted only while tripped.
// - Reset while running shuts the output stage off, motor coasts.
// - Reset clears thermal overload and brake duty accumulators.
// - Panel reset key works only while tripped, any guard setting.
// - Panel absent over 1 s with detection on: fault code, trip.
// - Guard 0,1,14,15: no panel-loss trip, keep running.
// - Panel absent since power-on is not a loss fault.
// - Continue-on-loss setting: loss during panel jog decelerates to stop.
// - Serial link via panel connector disables loss detection only.
// - Panel stop on: stop key decelerates in every mode.
// - Panel-stop latch blocks restart; its clear key works only from the stopping unit.
// - Power reset or accepted reset pin clears panel-stop latch.
// - Guard 0 to 3: no latch, stop key only in panel mode.
// - Panel stop in external mode decelerates even with coast selected.
// - Panel mode stop from non-selected unit sets the latch.
// - Source select 9999: parameter unit has priority over panel.
// - Write protect 0: writes only stopped in panel mode, except list.
// - Write protect 1: writes and clears rejected, short list writable.
// - Write protect 2: writes anywhere, only the operation mode setting rejected running.
// - Write protect setting itself is writable at all times.
// - Guard accepts 0-3, 14-17, defaults 14, survives parameter clear.
module misoperation_guard #(
  parameter LOSS_CYCLES = `MG_LOSS_CYCLES,
  parameter ACCUM_W = 16
) (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_reset,
  // Register port
  input wire [3:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  // Pins, panel keys and link
  input wire i_reset_input_pin,
  input wire i_link_reset,
  input wire i_link_via_panel,
  input wire i_panel_present,
  input wire i_panel_reset_key,
  input wire i_panel_stop_key,
  input wire i_unit_stop_key,
  input wire i_panel_clear,
  input wire i_unit_clear,
  input wire i_unit_present,
  input wire i_forward_start_input,
  input wire i_reverse_start_input,
  input wire i_jog_active,
  // Drive state
  input wire i_running,
  input wire i_fault,
  input wire i_thermal_inc,
  input wire i_brake_inc,
  // Output stage
  output reg o_output_off,
  output reg o_decel_stop,
  output reg o_tripped,
  output reg [7:0] o_fault_code,
  output reg o_panel_stop_latch,
  output reg o_start_enable
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers; stage one is read only by stage two
  localparam NSYNC = 11;
  wire [NSYNC-1:0] async_in = {i_reset_input_pin, i_link_reset, i_link_via_panel,
    i_panel_present, i_panel_reset_key, i_panel_stop_key, i_unit_stop_key,
    i_panel_clear, i_unit_clear, i_forward_start_input, i_reverse_start_input};
  reg [NSYNC-1:0] sync1_reg;
  reg [NSYNC-1:0] sync2_reg;
  reg [NSYNC-1:0] prev_reg;
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      sync1_reg <= {NSYNC{1'b0}};
      sync2_reg <= {NSYNC{1'b0}};
      prev_reg <= {NSYNC{1'b0}};
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end
  wire [NSYNC-1:0] rise = sync2_reg & ~prev_reg;
  wire pin_rst_p = rise[10];
  wire link_rst_p = rise[9];
  wire link_via_panel = sync2_reg[8];
  wire panel_here = sync2_reg[7];
  wire key_rst_p = rise[6];
  wire panel_stop_p = rise[5];
  wire unit_stop_p = rise[4];
  wire panel_clr_p = rise[3];
  wire unit_clr_p = rise[2];

  ////////////////////////////////////////////////////////////////////////
  // Setting registers
  reg [4:0] guard_reg;
  reg [1:0] wprot_reg;
  reg [13:0] stopsel_reg;
  reg [13:0] srcsel_reg;
  reg [1:0] opmode_reg;
  reg [9:0] last_pnum_reg;
  reg last_ok_reg;
  reg [ACCUM_W-1:0] thermal_reg;
  reg [ACCUM_W-1:0] brake_reg;

  function guard_valid;
    input [4:0] v;
    begin
      guard_valid = (v <= 5'h03) || (v >= 5'h0E && v <= 5'h11);
    end
  endfunction

  // Decode of a guard setting into its three features
  wire reset_trip_only = guard_reg[0];
  // Only legal codes are ever stored, so bits 4, 3 and 1 tell the groups apart:
  // 2, 3, 16 and 17 trip on panel loss; 14 to 17 stop from the panel in every mode
  wire loss_trip_en = guard_reg[4] | (!guard_reg[3] & guard_reg[1]);
  wire stop_all_modes = guard_reg[4] | guard_reg[3];

  // Parameter write gate
  function write_allowed;
    input [9:0] pnum;
    input [1:0] wp;
    input [1:0] mode;
    input run;
    reg always_ok;
    begin
      always_ok = (pnum == `MG_PNUM_GUARD) || (pnum == `MG_PNUM_DISPLAY) ||
        (pnum == `MG_PNUM_PW_LEVEL) || (pnum == `MG_PNUM_PW_LOCK);
      if (pnum == `MG_PNUM_WPROT)
        write_allowed = 1'b1;
      else if (wp == `MG_WP_INHIBIT)
        write_allowed = always_ok || (pnum == `MG_PNUM_STALL_LEVEL) ||
          (pnum == `MG_PNUM_OPMODE);
      else if (wp == `MG_WP_ALWAYS)
        write_allowed = !(run && pnum == `MG_PNUM_OPMODE);
      else
        write_allowed = always_ok ||
          (!run && mode == `MG_MODE_PANEL);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset acceptance
  wire ext_reset_ok = (pin_rst_p | link_rst_p) &&
    (!reset_trip_only || o_tripped);
  wire key_reset_ok = key_rst_p && o_tripped;
  wire reset_do = ext_reset_ok | key_reset_ok;
  wire pin_reset_do = pin_rst_p && (!reset_trip_only || o_tripped);

  ////////////////////////////////////////////////////////////////////////
  // Panel-loss timer
  reg seen_panel_reg;
  reg loss_fired_reg;
  reg [31:0] loss_cnt_reg;
  wire loss_armed = loss_trip_en && !link_via_panel && seen_panel_reg;
  wire loss_fire = loss_armed && !panel_here && !loss_fired_reg &&
    (loss_cnt_reg >= LOSS_CYCLES);

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      seen_panel_reg <= 1'b0;
      loss_fired_reg <= 1'b0;
      loss_cnt_reg <= 32'h0;
    end else begin
      if (panel_here)
        seen_panel_reg <= 1'b1;
      if (panel_here || !loss_armed) begin
        loss_cnt_reg <= 32'h0;
        loss_fired_reg <= 1'b0;
      end else begin
        if (loss_cnt_reg <= LOSS_CYCLES)
          loss_cnt_reg <= loss_cnt_reg + 32'h1;
        if (loss_fire)
          loss_fired_reg <= 1'b1;
      end
    end
  end

  // Continue-on-loss: loss while panel jog runs brings a controlled stop
  wire loss_jog_stop = !loss_trip_en && seen_panel_reg && !panel_here &&
    !link_via_panel && i_jog_active && opmode_reg == `MG_MODE_PANEL;

  ////////////////////////////////////////////////////////////////////////
  // Stop keys and panel-stop latch
  wire unit_is_source = (srcsel_reg == `MG_CODE_PU_PRIORITY) && i_unit_present;
  wire stop_any = panel_stop_p | unit_stop_p;
  wire stop_in_panel = stop_any && opmode_reg == `MG_MODE_PANEL;
  wire stop_effective = stop_all_modes ? stop_any : stop_in_panel;
  wire stop_foreign = (panel_stop_p && unit_is_source) ||
    (unit_stop_p && !unit_is_source);
  wire latch_set = stop_all_modes &&
    (opmode_reg != `MG_MODE_PANEL ? stop_any : stop_foreign);
  reg latch_by_unit_reg;
  wire latch_clear = o_panel_stop_latch &&
    (latch_by_unit_reg ? unit_clr_p : panel_clr_p);
  reg stopping_reg;

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_panel_stop_latch <= 1'b0;
      latch_by_unit_reg <= 1'b0;
      stopping_reg <= 1'b0;
    end else begin
      if (latch_set) begin
        o_panel_stop_latch <= 1'b1; // set wins over clear
        latch_by_unit_reg <= unit_stop_p && !panel_stop_p;
      end else if (latch_clear || pin_reset_do || !stop_all_modes)
        o_panel_stop_latch <= 1'b0;
      if (stop_effective || loss_jog_stop)
        stopping_reg <= 1'b1;
      else if (!i_running)
        stopping_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trip state, output stage and accumulators
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_tripped <= 1'b0;
      o_fault_code <= 8'h00;
      o_output_off <= 1'b0;
      o_decel_stop <= 1'b0;
      o_start_enable <= 1'b0;
      thermal_reg <= {ACCUM_W{1'b0}};
      brake_reg <= {ACCUM_W{1'b0}};
    end else begin
      if (loss_fire) begin
        o_tripped <= 1'b1;
        o_fault_code <= `MG_FAULT_PANEL_LOSS;
      end else if (i_fault)
        o_tripped <= 1'b1;
      else if (reset_do) begin
        o_tripped <= 1'b0;
        o_fault_code <= 8'h00;
      end
      // A reset cuts the output at once; stop selection plays no part
      o_output_off <= reset_do || loss_fire || i_fault ||
        (o_tripped && !reset_do);
      // Panel stop always brakes under control, coast selection ignored
      o_decel_stop <= stopping_reg || stop_effective || loss_jog_stop;
      o_start_enable <= !o_tripped && !o_panel_stop_latch && !stopping_reg;
      if (reset_do) begin
        thermal_reg <= {ACCUM_W{1'b0}};
        brake_reg <= {ACCUM_W{1'b0}};
      end else begin
        if (i_thermal_inc && thermal_reg != {ACCUM_W{1'b1}})
          thermal_reg <= thermal_reg + {{(ACCUM_W-1){1'b0}}, 1'b1};
        if (i_brake_inc && brake_reg != {ACCUM_W{1'b1}})
          brake_reg <= brake_reg + {{(ACCUM_W-1){1'b0}}, 1'b1};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port; a parameter write request is gated and its verdict kept
  wire wr_pnum_ok = write_allowed(i_wdata[9:0], wprot_reg, opmode_reg, i_running);
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      guard_reg <= `MG_GUARD_RESET;
      wprot_reg <= `MG_WPROT_RESET;
      stopsel_reg <= `MG_STOPSEL_RESET;
      srcsel_reg <= `MG_SRCSEL_RESET;
      opmode_reg <= `MG_OPMODE_RESET;
      last_pnum_reg <= 10'h000;
      last_ok_reg <= 1'b0;
      o_rdata <= 16'h0000;
    end else begin
      if (i_wr) begin
        case (i_addr)
          `MG_ADDR_GUARD: begin
            if (guard_valid(i_wdata[4:0]))
              guard_reg <= i_wdata[4:0];
          end
          `MG_ADDR_WPROT: begin
            if (i_wdata[1:0] != 2'h3)
              wprot_reg <= i_wdata[1:0];
          end
          `MG_ADDR_STOPSEL: stopsel_reg <= i_wdata[13:0];
          `MG_ADDR_SRCSEL: srcsel_reg <= i_wdata[13:0];
          `MG_ADDR_OPMODE: begin
            if (write_allowed(`MG_PNUM_OPMODE, wprot_reg, opmode_reg, i_running) &&
                i_wdata[1:0] != 2'h3)
              opmode_reg <= i_wdata[1:0];
          end
          `MG_ADDR_PARAM_REQ: begin
            last_pnum_reg <= i_wdata[9:0];
            // Bit 15 marks a clear request, refused under inhibit
            last_ok_reg <= i_wdata[15] ? (wprot_reg != `MG_WP_INHIBIT) :
              wr_pnum_ok;
          end
          default: ;
        endcase
      end
      if (i_rd) begin
        case (i_addr)
          `MG_ADDR_GUARD: o_rdata <= {11'h000, guard_reg};
          `MG_ADDR_WPROT: o_rdata <= {14'h0000, wprot_reg};
          `MG_ADDR_STOPSEL: o_rdata <= {2'h0, stopsel_reg};
          `MG_ADDR_SRCSEL: o_rdata <= {2'h0, srcsel_reg};
          `MG_ADDR_OPMODE: o_rdata <= {14'h0000, opmode_reg};
          `MG_ADDR_PARAM_REQ: o_rdata <= {last_ok_reg, 5'h00, last_pnum_reg};
          `MG_ADDR_STATUS: o_rdata <= {5'h00, o_start_enable, o_decel_stop,
            o_output_off, o_panel_stop_latch, o_tripped, o_fault_code[5:0]};
          `MG_ADDR_ACCUM: o_rdata <= thermal_reg | brake_reg;
          default: o_rdata <= 16'h0000;
        endcase
      end else
        o_rdata <= 16'h0000;
    end
  end

endmodule

// file: dv/misoperation_guard_properties.sv
/*
  Port checker for the misoperation guard.
  Assumes it is bound to the top module; the guard code is followed from bus writes.
*/
`timescale 1ns/1ns
module misoperation_guard_properties #(
  parameter LOSS_CYCLES = 20
) (
  // Clock, reset and register port
  input wire i_clk_sys,
  input wire i_reset,
  input wire [3:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [15:0] o_rdata,
  // Pins and keys
  input wire i_reset_input_pin,
  input wire i_panel_present,
  input wire i_unit_stop_key,
  input wire i_panel_clear,
  input wire i_unit_clear,
  input wire i_running,
  // Outputs watched
  input wire o_output_off,
  input wire o_decel_stop,
  input wire o_tripped,
  input wire [7:0] o_fault_code,
  input wire o_panel_stop_latch
);
  reg [4:0] guard_q;
  reg seen_q;
  reg [3:0] clr_h;
  integer gone;
  wire clr_now = i_panel_clear | i_unit_clear | i_reset_input_pin;
  // Copy takes legal codes only, so a refused write cannot mislead the checks
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      guard_q <= 5'h0E;
      seen_q <= 1'b0;
      clr_h <= 4'h0;
      gone <= 0;
    end else begin
      if (i_wr && i_addr == 4'h0 && (i_wdata < 16'h4 || (i_wdata > 16'hD && i_wdata < 16'h12)))
        guard_q <= i_wdata[4:0];
      seen_q <= seen_q | i_panel_present;
      clr_h <= {clr_h[2:0], clr_now};
      gone <= i_panel_present ? 0 : gone + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  sequence s_trip_then_off;
    o_tripped ##1 o_output_off;
  endsequence
  property p_loss_trip;
    $rose(o_fault_code == 8'h41) |-> seen_q && (guard_q[4] | (!guard_q[3] & guard_q[1])) &&
      gone > LOSS_CYCLES ##0 s_trip_then_off;
  endproperty
  a_loss_trip: assert property (p_loss_trip) else $error("loss trip out of place");
  property p_no_early;
    !seen_q |-> o_fault_code != 8'h41;
  endproperty
  a_no_early: assert property (p_no_early) else $error("loss without panel");
  property p_rd_idle;
    !$past(i_rd) |-> o_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
  property p_reset_clear;
    $fell(i_reset) |-> !(o_tripped | o_output_off | o_decel_stop | o_panel_stop_latch);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state kept over reset");
  property p_pin_coast;
    $rose(i_reset_input_pin) && i_running && !guard_q[0] |-> ##[2:6] o_output_off;
  endproperty
  a_pin_coast: assert property (p_pin_coast) else $error("reset did not coast");
  property p_key_decel;
    $rose(i_unit_stop_key) && i_running && guard_q > 5'h0D |-> ##[2:6] o_decel_stop;
  endproperty
  a_key_decel: assert property (p_key_decel) else $error("stop key ignored");
  property p_no_latch;
    guard_q < 5'h04 && !o_panel_stop_latch |=> !o_panel_stop_latch;
  endproperty
  a_no_latch: assert property (p_no_latch) else $error("latch while disabled");
  property p_latch_hold;
    o_panel_stop_latch && clr_h == 4'h0 && !clr_now |=> o_panel_stop_latch;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch dropped alone");
endmodule
bind misoperation_guard misoperation_guard_properties #(.LOSS_CYCLES(LOSS_CYCLES)) u_props (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_reset_input_pin(i_reset_input_pin),
  .i_panel_present(i_panel_present), .i_unit_stop_key(i_unit_stop_key),
  .i_panel_clear(i_panel_clear), .i_unit_clear(i_unit_clear), .i_running(i_running),
  .o_output_off(o_output_off), .o_decel_stop(o_decel_stop), .o_tripped(o_tripped),
  .o_fault_code(o_fault_code), .o_panel_stop_latch(o_panel_stop_latch)
);

// file: dv/panel_model.sv
/*
  Far side model: operator panel presence and the keys of panel and parameter unit.
  Assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/1ns
module panel_model (
  // Clock
  input wire i_clk_sys,
  // Lines toward the guard
  output reg o_panel_present,
  output reg [4:0] o_keys
);
  // Keys: panel stop, unit stop, panel clear, unit clear, panel reset
  initial begin
    o_panel_present = 1'b0;
    o_keys = 5'h00;
  end
  task attach(input on);
    o_panel_present <= on;
  endtask
  // Held three cycles so the two-flop synchroniser never misses a press
  task press(input [4:0] k);
    begin
      o_keys <= k; // any key is sent as given; a clear may come from either unit
      repeat (3) @(posedge i_clk_sys);
      o_keys <= 5'h00;
      repeat (3) @(posedge i_clk_sys);
    end
  endtask
endmodule

// file: dv/misoperation_guard_tb.sv
/*
  Bench for the misoperation guard: registers, write gate, resets, stop latch, panel loss.
  Assumes the panel model and the bound port checker.
*/
`timescale 1ns/1ns
`include "misoperation_guard_defines.vh"
module misoperation_guard_tb;
  localparam LOSS = 20;
  // Rows: write protect, running, clear, expected ok, parameter number
  localparam [119:0] TBL = {15'h504F, 15'h5450, 15'h2850, 15'h2416,
    15'h2050, 15'h144B, 15'h1050, 15'h0450};
  reg i_clk_sys = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  reg [3:0] i_addr = 4'h0;
  reg [15:0] i_wdata = 16'h0000;
  reg pin = 1'b0, via = 1'b0, run = 1'b0, inc = 1'b0, lo = 1'b0, unit = 1'b0;
  reg lrst = 1'b0, jog = 1'b0, flt = 1'b0, hit = 1'b0;
  wire [15:0] rdata;
  wire [7:0] code;
  wire [4:0] ks;
  wire pp, off, decel, trip, latch, sten;
  reg [14:0] row;
  integer n_mismatch = 0, tests_run = 0, cyc = 0, i;
  initial forever #50 i_clk_sys = ~i_clk_sys;
  panel_model u_pan (.i_clk_sys(i_clk_sys), .o_panel_present(pp), .o_keys(ks));
  misoperation_guard #(.LOSS_CYCLES(LOSS)) u_dut (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_reset_input_pin(pin),
    .i_link_reset(lrst), .i_link_via_panel(via), .i_panel_present(pp),
    .i_panel_reset_key(ks[4]), .i_panel_stop_key(ks[0]), .i_unit_stop_key(ks[1]),
    .i_panel_clear(ks[2]), .i_unit_clear(ks[3]), .i_unit_present(unit),
    .i_forward_start_input(lo), .i_reverse_start_input(lo), .i_jog_active(jog),
    .i_running(run), .i_fault(flt), .i_thermal_inc(inc), .i_brake_inc(inc),
    .o_output_off(off), .o_decel_stop(decel), .o_tripped(trip), .o_fault_code(code),
    .o_panel_stop_latch(latch), .o_start_enable(sten)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
      // One idle edge, so a following write never sets the strobe in the same step
      @(posedge i_clk_sys);
    end
  endtask
  // Data of a read stand one cycle only, so they are taken at the next edge
  task rd(input [3:0] a, input [15:0] exp);
    begin
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      @(posedge i_clk_sys);
      chk(rdata, exp);
    end
  endtask
  // Reset request held six cycles; the cut of the output lasts one cycle, so it is caught
  task rst_hold(input link);
    integer k;
    begin
      hit = 1'b0;
      if (link) lrst <= 1'b1;
      else pin <= 1'b1;
      for (k = 0; k < 6; k = k + 1) begin
        @(posedge i_clk_sys);
        hit = hit | off;
      end
      lrst <= 1'b0;
      pin <= 1'b0;
    end
  endtask
  task trip_it;
    begin
      flt <= 1'b1;
      @(posedge i_clk_sys);
      flt <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
    end
  endtask
  task por;
    begin
      i_reset <= 1'b1;
      run <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      @(posedge i_clk_sys);
    end
  endtask
  always @(posedge i_clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      end_sim;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_reset <= 1'b0; // start inputs stay low through resets and restarts
    @(posedge i_clk_sys);
    rd(`MG_ADDR_GUARD, 16'h000E);
    rd(`MG_ADDR_WPROT, 16'h0000);
    rd(`MG_ADDR_STOPSEL, 16'h270F);
    rd(`MG_ADDR_SRCSEL, 16'h270F);
    rd(4'h9, 16'h0000);
    wr(`MG_ADDR_GUARD, 16'h0005);
    rd(`MG_ADDR_GUARD, 16'h000E);
    for (i = 0; i < 8; i = i + 1) begin
      row = TBL[i*15 +: 15];
      wr(`MG_ADDR_WPROT, {14'h0, row[14:13]});
      rd(`MG_ADDR_WPROT, {14'h0, row[14:13]});
      run <= row[12];
      wr(`MG_ADDR_PARAM_REQ, {row[11], 5'h00, row[9:0]});
      rd(`MG_ADDR_PARAM_REQ, {row[10], 5'h00, row[9:0]});
    end
    wr(`MG_ADDR_WPROT, 16'h0000);
    $display("test registers and write gate done");
    inc <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    inc <= 1'b0;
    wr(`MG_ADDR_GUARD, 16'h000F);
    run <= 1'b1;
    rst_hold(1'b0);
    chk(hit, 1'b0);
    u_pan.press(5'h10);
    rd(`MG_ADDR_ACCUM, 16'h0003);
    trip_it;
    chk({trip, sten}, 2'h2);
    u_pan.press(5'h10);
    chk(trip, 1'b0);
    rd(`MG_ADDR_ACCUM, 16'h0000);
    trip_it;
    rst_hold(1'b1);
    chk(trip, 1'b0);
    inc <= 1'b1;
    @(posedge i_clk_sys);
    inc <= 1'b0;
    wr(`MG_ADDR_GUARD, 16'h000E);
    rst_hold(1'b0);
    chk(hit, 1'b1);
    rd(`MG_ADDR_ACCUM, 16'h0000);
    $display("test reset acceptance done");
    por;
    wr(`MG_ADDR_STOPSEL, 16'h0000);
    wr(`MG_ADDR_OPMODE, 16'h0001);
    run <= 1'b1;
    u_pan.press(5'h02);
    chk({decel, latch}, 2'h3);
    u_pan.press(5'h04);
    chk(latch, 1'b1);
    u_pan.press(5'h08);
    chk(latch, 1'b0);
    u_pan.press(5'h02);
    chk(latch, 1'b1);
    rst_hold(1'b0);
    chk(latch, 1'b0);
    por;
    wr(`MG_ADDR_GUARD, 16'h0002);
    wr(`MG_ADDR_OPMODE, 16'h0001);
    run <= 1'b1;
    u_pan.press(5'h02);
    chk({decel, latch}, 2'h0);
    por;
    run <= 1'b1;
    u_pan.press(5'h01);
    chk(latch, 1'b0);
    unit <= 1'b1;
    u_pan.press(5'h01);
    chk(latch, 1'b1);
    $display("test panel stop done");
    por;
    wr(`MG_ADDR_GUARD, 16'h0010);
    repeat (40) @(posedge i_clk_sys);
    chk(trip, 1'b0);
    u_pan.attach(1'b1);
    repeat (5) @(posedge i_clk_sys);
    u_pan.attach(1'b0);
    repeat (15) @(posedge i_clk_sys);
    u_pan.attach(1'b1);
    repeat (3) @(posedge i_clk_sys);
    u_pan.attach(1'b0);
    repeat (15) @(posedge i_clk_sys);
    chk(trip, 1'b0);
    repeat (20) @(posedge i_clk_sys);
    chk({trip, code}, 9'h141);
    jog <= 1'b1;
    for (i = 0; i < 2; i = i + 1) begin
      por;
      via <= i[0];
      wr(`MG_ADDR_GUARD, i ? 16'h0010 : 16'h000E);
      u_pan.attach(1'b1);
      repeat (5) @(posedge i_clk_sys);
      u_pan.attach(1'b0);
      repeat (40) @(posedge i_clk_sys);
      chk({trip, decel}, {1'b0, ~i[0]});
    end
    $display("test panel loss done");
    end_sim;
  end
endmodule
